// File: hsif_pkg.sv
/*
 * Shared constants for the host-side interrupt and queue register block:
 * host offsets, bit positions, local control fields, reset values, link states.
 * Assumes a 7-bit host byte address space and an 8-bit host data path.
 */
package hsif_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // host offsets
    localparam logic [6:0] OFF_RAM_LAST   = 7'h77;
    localparam logic [6:0] OFF_ENABLE     = 7'h78;
    localparam logic [6:0] OFF_STATUS     = 7'h79;
    localparam logic [6:0] OFF_CLEAR      = 7'h7A;
    localparam logic [6:0] OFF_FORCE      = 7'h7B;
    localparam logic [6:0] OFF_COUNT_LOW  = 7'h7C;
    localparam logic [6:0] OFF_COUNT_HIGH = 7'h7D;
    localparam logic [6:0] OFF_QUEUE      = 7'h7F;

    ////////////////////////////////////////////////////////////////////////////
    // host status / enable bit positions
    localparam int BIT_UNDERFLOW   = 7;
    localparam int BIT_LOCKED_READ = 6;
    localparam int SOFT_MSB        = 5;
    localparam int SOFT_LSB        = 0;

    // fill count split
    localparam int COUNT_WIDTH    = 10;
    localparam int COUNT_LOW_MSB  = 7;
    localparam int COUNT_HIGH_MSB = 9;
    localparam int COUNT_HIGH_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////
    // local control word fields
    localparam int LCL_SET_MSB    = 31;
    localparam int LCL_SET_LSB    = 24;
    localparam int LCL_CLEAR_ALL  = 16;
    localparam int LCL_STAT_MSB   = 15;
    localparam int LCL_STAT_LSB   = 8;
    localparam int LCL_EN_MSB     = 7;
    localparam int LCL_EN_LSB     = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // link-side sequencer, gray along idle -> wait -> done
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_WAIT = 2'b01,
        LINK_DONE = 2'b11
    } hsif_link_state_t;

    // offsets that belong to the direct ram area
    function automatic logic hsif_is_ram(input logic [6:0] addr);
        hsif_is_ram = (addr <= OFF_RAM_LAST);
    endfunction : hsif_is_ram

endpackage : hsif_pkg

// File: hsif_stream_if.sv
/*
 * Valid/ready stream carrier between the register block and its two-entry
 * buffer. Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface hsif_stream_if #(
    parameter int WIDTH = 8
);
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] inData;
    logic             outValid;
    logic             outReady;
    logic [WIDTH-1:0] outData;

    modport buffer (
        input  inValid,
        input  inData,
        input  outReady,
        output inReady,
        output outValid,
        output outData
    );

    modport user (
        output inValid,
        output inData,
        output outReady,
        input  inReady,
        input  outValid,
        input  outData
    );
endinterface : hsif_stream_if

// File: hsif_buf2.sv
/*
 * Two-entry valid/ready buffer, registered data output.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module hsif_buf2 #(
    parameter int WIDTH = 8
) (
    input  wire logic      mclk,
    input  wire logic      rstn,
    hsif_stream_if.buffer  s
);
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0]       fill;
    logic             push;
    logic             pop;

    assign s.inReady  = (fill != 2'h2);
    assign s.outValid = (fill != 2'h0);
    assign s.outData  = slot0;
    assign push       = s.inValid & s.inReady;
    assign pop        = s.outReady & s.outValid;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            fill <= 2'h0;
        end else if (push && !pop) begin
            fill <= fill + 2'h1;
        end else if (pop && !push) begin
            fill <= fill - 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slot0 <= '0;
            slot1 <= '0;
        end else begin
            if (pop) begin
                slot0 <= (push && fill == 2'h1) ? s.inData : slot1;
                if (push && fill == 2'h2) begin
                    slot1 <= s.inData;
                end
            end else if (push) begin
                if (fill == 2'h0) begin
                    slot0 <= s.inData;
                end else begin
                    slot1 <= s.inData;
                end
            end
        end
    end
endmodule : hsif_buf2

// File: hsif_host_regs.sv
/*
 * Host-facing interrupt and queue register block of a serial slave port.
 * Host accesses arrive on the link clock, are handed to the module clock,
 * executed there, and answered back across the same handshake.
 * Assumes the serial front end presents one byte access at a time and
 * waits while hostBusy is high; the local side and queue share mclk.
 */
`timescale 1ns/1ps
module hsif_host_regs #(
    parameter int DATA_WIDTH = 8
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  linkClk,
    input  wire logic [6:0]            hostAddr,
    input  wire logic                  hostWrite,
    input  wire logic                  hostRead,
    input  wire logic [DATA_WIDTH-1:0] hostWdata,
    output logic                       hostBusy,
    output logic                       hostRspValid,
    output logic [DATA_WIDTH-1:0]      hostRdata,
    output logic                       hostIrq,
    input  wire logic                  localWrite,
    input  wire logic [31:0]           localWdata,
    output logic [31:0]                localHostIrqCtrl,
    input  wire logic [9:0]            fillCount,
    input  wire logic                  queueUpdateBusy,
    input  wire logic                  queueValid,
    input  wire logic [DATA_WIDTH-1:0] queueData,
    output logic                       queueReady,
    output logic                       ramWrite,
    output logic                       ramRead,
    output logic [6:0]                 ramAddr,
    output logic [DATA_WIDTH-1:0]      ramWdata,
    input  wire logic [DATA_WIDTH-1:0] ramRdata
);

    ////////////////////////////////////////////////////////////////////////////
    // link domain: request capture and answer
    hsif_pkg::hsif_link_state_t linkState;
    logic                  reqToggle;
    logic [6:0]            reqAddr;
    logic [DATA_WIDTH-1:0] reqWdata;
    logic                  reqIsWrite;
    logic                  ackSync1;
    logic                  ackSync2;
    logic                  ackSeen;

    // mclk domain request side
    logic                  reqSync1;
    logic                  reqSync2;
    logic                  reqSeen;
    logic                  reqStrobe;
    logic                  ackToggle;
    logic [DATA_WIDTH-1:0] rspData;

    assign hostBusy = (linkState != hsif_pkg::LINK_IDLE);

    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            ackSync1 <= 1'b0;
            ackSync2 <= 1'b0;
        end else begin
            ackSync1 <= ackToggle;
            ackSync2 <= ackSync1;
        end
    end

    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            linkState    <= hsif_pkg::LINK_IDLE;
            reqToggle    <= 1'b0;
            reqAddr      <= 7'h00;
            reqWdata     <= hsif_pkg::RST_BYTE;
            reqIsWrite   <= 1'b0;
            ackSeen      <= 1'b0;
            hostRspValid <= 1'b0;
            hostRdata    <= hsif_pkg::RST_BYTE;
        end else begin
            case (linkState)
                hsif_pkg::LINK_IDLE: begin
                    hostRspValid <= 1'b0;
                    if (hostWrite || hostRead) begin
                        reqAddr    <= hostAddr;
                        reqWdata   <= hostWdata;
                        reqIsWrite <= hostWrite;
                        reqToggle  <= ~reqToggle;
                        linkState  <= hsif_pkg::LINK_WAIT;
                    end
                end
                hsif_pkg::LINK_WAIT: begin
                    // rspData is held still by mclk once ack has toggled
                    if (ackSync2 != ackSeen) begin
                        ackSeen      <= ackSync2;
                        hostRdata    <= reqIsWrite ? hsif_pkg::RST_BYTE : rspData;
                        hostRspValid <= 1'b1;
                        linkState    <= hsif_pkg::LINK_DONE;
                    end
                end
                hsif_pkg::LINK_DONE: begin
                    hostRspValid <= 1'b0;
                    linkState    <= hsif_pkg::LINK_IDLE;
                end
                default: begin
                    hostRspValid <= 1'b0;
                    linkState    <= hsif_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mclk domain: request sync and one-cycle execute slot
    logic                  opValid;
    logic [6:0]            opAddr;
    logic [DATA_WIDTH-1:0] opWdata;
    logic                  opWrite;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reqSync1 <= 1'b0;
            reqSync2 <= 1'b0;
            reqSeen  <= 1'b0;
        end else begin
            reqSync1 <= reqToggle;
            reqSync2 <= reqSync1;
            reqSeen  <= reqSync2;
        end
    end

    assign reqStrobe = (reqSync2 != reqSeen);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            opValid <= 1'b0;
            opAddr  <= 7'h00;
            opWdata <= hsif_pkg::RST_BYTE;
            opWrite <= 1'b0;
        end else begin
            opValid <= reqStrobe;
            if (reqStrobe) begin
                opAddr  <= reqAddr;
                opWdata <= reqWdata;
                opWrite <= reqIsWrite;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ram area pass-through
    // low offsets to ram
    assign ramWrite = opValid & opWrite & hsif_pkg::hsif_is_ram(opAddr);
    assign ramRead  = opValid & ~opWrite & hsif_pkg::hsif_is_ram(opAddr);
    assign ramAddr  = opAddr;
    assign ramWdata = opWdata;

    ////////////////////////////////////////////////////////////////////////////
    // queue buffer
    hsif_stream_if #(.WIDTH(DATA_WIDTH)) qs ();

    hsif_buf2 #(
        .WIDTH (DATA_WIDTH)
    ) u_buf (
        .mclk (mclk),
        .rstn (rstn),
        .s    (qs.buffer)
    );

    logic queueRead;
    logic wrEnable;
    logic wrClear;
    logic wrForce;

    assign queueRead  = opValid & ~opWrite & (opAddr == hsif_pkg::OFF_QUEUE);
    assign wrEnable   = opValid & opWrite & (opAddr == hsif_pkg::OFF_ENABLE);
    assign wrClear    = opValid & opWrite & (opAddr == hsif_pkg::OFF_CLEAR);
    assign wrForce    = opValid & opWrite & (opAddr == hsif_pkg::OFF_FORCE);
    assign qs.inValid  = queueValid;
    assign qs.inData   = queueData;
    assign queueReady  = qs.inReady;
    assign qs.outReady = queueRead;

    ////////////////////////////////////////////////////////////////////////////
    // enables and pending statuses
    logic [7:0] hostIrqEnable;
    logic [7:0] hostIrqStatus;
    logic [7:0] hwEvents;
    logic [7:0] setMask;
    logic [7:0] clearMask;
    logic [7:0] next_status;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostIrqEnable <= hsif_pkg::RST_ENABLE;
        end else if (wrEnable) begin
            hostIrqEnable <= opWdata[7:0];
        end
    end

    always_comb begin
        hwEvents = 8'h00;
        hwEvents[hsif_pkg::BIT_UNDERFLOW] = queueRead & (fillCount == 10'h000);
        hwEvents[hsif_pkg::BIT_LOCKED_READ] = queueRead & queueUpdateBusy;
        setMask = hwEvents;
        if (localWrite) begin
            setMask = setMask | localWdata[hsif_pkg::LCL_SET_MSB:hsif_pkg::LCL_SET_LSB];
        end
        if (wrForce) begin
            setMask = setMask | opWdata[7:0];
        end
        clearMask = 8'h00;
        if (wrClear) begin
            clearMask = opWdata[7:0];
        end
        if (localWrite && localWdata[hsif_pkg::LCL_CLEAR_ALL]) begin
            clearMask = 8'hFF;
        end
        // zero bits leave status alone; set beats clear
        next_status = (hostIrqStatus & ~clearMask) | setMask;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostIrqStatus <= hsif_pkg::RST_STATUS;
        end else begin
            hostIrqStatus <= next_status;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hostIrq <= 1'b0;
        end else begin
            hostIrq <= |(next_status & hostIrqEnable);
        end
    end

    assign localHostIrqCtrl = {8'h00, 7'h00, 1'b0, hostIrqStatus, hostIrqEnable};

    ////////////////////////////////////////////////////////////////////////////
    // host read data and answer toggle
    logic [DATA_WIDTH-1:0] readMux;

    always_comb begin
        readMux = hsif_pkg::RST_BYTE;
        if (hsif_pkg::hsif_is_ram(opAddr)) begin
            readMux = ramRdata;
        end else begin
            case (opAddr)
                hsif_pkg::OFF_ENABLE:     readMux = hostIrqEnable;
                hsif_pkg::OFF_STATUS:     readMux = hostIrqStatus;
                hsif_pkg::OFF_COUNT_LOW:  readMux = fillCount[hsif_pkg::COUNT_LOW_MSB:0];
                hsif_pkg::OFF_COUNT_HIGH: readMux = {6'h00,
                    fillCount[hsif_pkg::COUNT_HIGH_MSB:hsif_pkg::COUNT_HIGH_LSB]};
                hsif_pkg::OFF_QUEUE:      readMux = qs.outValid ? qs.outData
                                                                : hsif_pkg::RST_BYTE;
                default:                  readMux = hsif_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rspData   <= hsif_pkg::RST_BYTE;
            ackToggle <= 1'b0;
        end else if (opValid) begin
            if (!opWrite) begin
                rspData <= readMux;
            end
            ackToggle <= ~ackToggle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_underflow_set: assert property (
        queueRead && fillCount == 10'h000 |=> hostIrqStatus[7])
        else $error("underflow status not set on empty read");

    a_locked_read_set: assert property (
        queueRead && queueUpdateBusy |=> hostIrqStatus[6])
        else $error("read error status not set on busy read");

    a_soft_local_set: assert property (
        localWrite |=> (hostIrqStatus[5:0] & $past(localWdata[29:24]))
                       == $past(localWdata[29:24]))
        else $error("soft status not set by local write");

    a_clear_all: assert property (
        localWrite && localWdata[16] && localWdata[31:24] == 8'h00 && !opValid
        |=> hostIrqStatus == 8'h00)
        else $error("clear-all left a status set");

    a_host_clear: assert property (
        wrClear && !localWrite
        |=> (hostIrqStatus & $past(opWdata)) == 8'h00
            && (hostIrqStatus | $past(opWdata)) == ($past(hostIrqStatus) | $past(opWdata)))
        else $error("host clear wrong");

    a_host_force: assert property (
        wrForce |=> (hostIrqStatus & $past(opWdata)) == $past(opWdata))
        else $error("host force did not set status");

    a_count_high: assert property (
        opValid && !opWrite && opAddr == hsif_pkg::OFF_COUNT_HIGH
        |=> rspData == {6'h00, $past(fillCount[9:8])})
        else $error("count high byte wrong");

    a_queue_head: assert property (
        queueRead && qs.outValid |=> rspData == $past(qs.outData))
        else $error("queue head byte wrong");

    a_irq_gate: assert property (
        (|(hostIrqStatus & hostIrqEnable)) ##1 (|(hostIrqStatus & hostIrqEnable))
        |-> hostIrq)
        else $error("interrupt low with enabled pending status");

    a_irq_quiet: assert property (
        hostIrqEnable == 8'h00 |=> !hostIrq)
        else $error("interrupt high with nothing enabled");

    a_ack_turn: assert property (
        reqStrobe |-> ##2 (ackToggle != $past(ackToggle, 2)))
        else $error("answer not turned in two cycles");

endmodule : hsif_host_regs

// File: hsif_host_model.sv
/*
 * Host master model: runs the link clock from start-up through the first access,
 * then only while one is in flight, and makes one byte access at a time on the host request port.
 * Assumes the block answers every request with one response pulse.
 */
`timescale 1ns/1ps
module hsif_host_model (
    output logic            linkClk,
    output logic [6:0]      hostAddr,
    output logic            hostWrite,
    output logic            hostRead,
    output logic [7:0]      hostWdata,
    input  wire logic       hostRspValid,
    input  wire logic [7:0] hostRdata
);
    logic frameOn;
    int   lost;

    // clock stands still low between accesses
    initial begin
        linkClk   = 1'b0;
        frameOn   = 1'b1;
        hostAddr  = 7'h00;
        hostWrite = 1'b0;
        hostRead  = 1'b0;
        hostWdata = 8'h00;
        lost      = 0;
        #1.7;
        forever #6 if (frameOn || linkClk) linkClk = ~linkClk;
    end

    // bytes written exactly as given, one access at a time
    task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                          input int gap, output logic [7:0] q);
        int n;
        n = 0;
        frameOn = 1'b1;
        repeat (3 + gap) @(negedge linkClk);
        hostAddr  = a;
        hostWdata = d;
        hostWrite = wr;
        hostRead  = ~wr;
        @(negedge linkClk);
        hostWrite = 1'b0;
        hostRead  = 1'b0;
        hostAddr  = ~a;
        hostWdata = ~d;
        while (hostRspValid !== 1'b1 && n < 16) begin
            @(negedge linkClk);
            n++;
        end
        if (n == 16) lost++;
        q = hostRdata;
        repeat (2) @(negedge linkClk);
        frameOn = 1'b0;
    endtask : access
endmodule : hsif_host_model

// File: tb_top.sv
/*
 * Self-checking bench for the host interrupt and queue register block.
 * Assumes the host model owns the link side; local word and queue are
 * driven here on the falling edge of mclk, ram read data from ramAddr.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
    logic        mclk = 1'b0, rstn = 1'b0, localWrite = 1'b0, queueUpdateBusy = 1'b0;
    logic        queueValid = 1'b0, linkClk, hostWrite, hostRead, hostBusy, hostRspValid;
    logic        hostIrq, queueReady, ramWrite, ramRead, took;
    logic [31:0] localWdata = 32'h0, localHostIrqCtrl;
    logic [9:0]  fillCount = 10'h000;
    logic [9:0]  fcs[4];
    logic [7:0]  queueData = 8'h00, hostWdata, hostRdata, ramWdata, ramRdata, seenD;
    logic [7:0]  en = 8'h00, stat = 8'h00, q, d;
    logic [6:0]  hostAddr, ramAddr, seenA;
    logic [6:0]  zeroOff[3] = '{7'h7A, 7'h7B, 7'h7E};
    logic [7:0]  mq[$];
    int          ramHits = 0;
    int          ramReads = 0;
    int          n_mismatch = 0;
    int          num_checks = 0;

    hsif_host_regs dut (
        .mclk, .rstn, .linkClk, .hostAddr, .hostWrite, .hostRead, .hostWdata, .hostBusy,
        .hostRspValid, .hostRdata, .hostIrq, .localWrite, .localWdata, .localHostIrqCtrl,
        .fillCount, .queueUpdateBusy, .queueValid, .queueData, .queueReady,
        .ramWrite, .ramRead, .ramAddr, .ramWdata, .ramRdata
    );
    hsif_host_model host (
        .linkClk, .hostAddr, .hostWrite, .hostRead, .hostWdata, .hostRspValid, .hostRdata
    );

    always #2 mclk = ~mclk;
    assign ramRdata = {1'b0, ramAddr} ^ 8'hA5;
    // ram strobes sampled mid-cycle, away from the launching edge
    always @(negedge mclk) begin
        if (ramWrite === 1'b1) begin
            ramHits++;
            seenA = ramAddr;
            seenD = ramWdata;
        end
        if (ramRead === 1'b1) begin
            ramReads++;
        end
    end

    // busy must cover the answer pulse
    always @(negedge linkClk) begin
        if (hostRspValid === 1'b1) begin
            `CHK(hostBusy, 1'b1)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic hw(input logic [6:0] a, input logic [7:0] wd);
        logic [7:0] r;
        host.access(1'b1, a, wd, $urandom_range(3), r);
        case (a)
            hsif_pkg::OFF_ENABLE: en = wd;
            hsif_pkg::OFF_CLEAR:  stat = stat & ~wd;
            hsif_pkg::OFF_FORCE:  stat = stat | wd;
            default: ;
        endcase
    endtask : hw

    task automatic hr(input logic [6:0] a, output logic [7:0] r);
        host.access(1'b0, a, 8'h00, $urandom_range(3), r);
        if (a == hsif_pkg::OFF_QUEUE) begin
            stat = stat | {fillCount == 10'h000, queueUpdateBusy, 6'h00};
        end
    endtask : hr

    task automatic lw(input logic [31:0] w);
        @(negedge mclk);
        localWrite = 1'b1;
        localWdata = w;
        @(negedge mclk);
        localWrite = 1'b0;
        localWdata = ~w;
        @(negedge mclk);
        stat = (w[16] ? 8'h00 : stat) | w[31:24];
    endtask : lw

    task automatic chkAll();
        logic [7:0] r;
        hr(hsif_pkg::OFF_STATUS, r);
        `CHK(r, stat)
        hr(hsif_pkg::OFF_ENABLE, r);
        `CHK(r, en)
        @(negedge mclk);
        `CHK(localHostIrqCtrl, {16'h0000, stat, en})
        `CHK(hostIrq, |(stat & en))
        `CHK(hostBusy, 1'b0)
    endtask : chkAll

    task automatic results();
        `CHK(host.lost, 0)
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    initial begin
        #200us;
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h06c59221));
        fcs = '{10'h000, 10'h3FF, 10'h155, 10'($urandom)};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(localHostIrqCtrl, 32'h0000_0000)
        chkAll();
        hw(hsif_pkg::OFF_ENABLE, 8'($urandom));
        for (int i = 0; i < 8; i++) begin
            lw(32'h0000_0001 << (24 + i));
            `CHK(localHostIrqCtrl[15:8], stat)
            `CHK(hostIrq, |(stat & en))
        end
        lw(32'h0001_0000);
        `CHK(localHostIrqCtrl[15:8], 8'h00)
        hw(hsif_pkg::OFF_FORCE, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            hw(hsif_pkg::OFF_ENABLE, 8'h01 << i);
            hw(hsif_pkg::OFF_CLEAR, 8'h01 << i);
            `CHK(hostIrq, |(stat & en))
            hw(hsif_pkg::OFF_FORCE, 8'h01 << i);
            `CHK(hostIrq, |(stat & en))
        end
        repeat (6) begin
            hw(hsif_pkg::OFF_FORCE, 8'($urandom));
            hw(hsif_pkg::OFF_CLEAR, 8'($urandom));
            hw(hsif_pkg::OFF_ENABLE, 8'($urandom));
            chkAll();
        end
        hw(hsif_pkg::OFF_STATUS, ~stat);
        hw(hsif_pkg::OFF_COUNT_LOW, 8'hFF);
        chkAll();
        foreach (zeroOff[k]) begin
            hr(zeroOff[k], q);
            `CHK(q, 8'h00)
        end
        foreach (fcs[k]) begin
            @(negedge mclk);
            fillCount = fcs[k];
            hr(hsif_pkg::OFF_COUNT_LOW, q);
            `CHK(q, fcs[k][7:0])
            hr(hsif_pkg::OFF_COUNT_HIGH, q);
            `CHK(q, {6'h00, fcs[k][9:8]})
        end
        // queue filled until refused, then drained by a slow host
        @(negedge mclk);
        fillCount = 10'h003;
        queueValid = 1'b1;
        queueData = 8'($urandom);
        for (int i = 0; i < 4; i++) begin
            took = queueReady;
            @(negedge mclk);
            if (took === 1'b1) begin
                mq.push_back(queueData);
                queueData = 8'($urandom);
            end
        end
        `CHK(queueReady, 1'b0)
        queueValid = 1'b0;
        repeat (3) begin
            d = (mq.size() > 0) ? mq.pop_front() : 8'h00;
            hr(hsif_pkg::OFF_QUEUE, q);
            `CHK(q, d)
        end
        chkAll();
        @(negedge mclk);
        fillCount = 10'h000;
        hr(hsif_pkg::OFF_QUEUE, q);
        `CHK(q, 8'h00)
        chkAll();
        @(negedge mclk);
        fillCount = 10'h005;
        queueUpdateBusy = 1'b1;
        hr(hsif_pkg::OFF_QUEUE, q);
        @(negedge mclk);
        queueUpdateBusy = 1'b0;
        chkAll();
        `CHK(ramHits, 0)
        `CHK(ramReads, 0)
        d = 8'($urandom);
        hw(hsif_pkg::OFF_RAM_LAST, d);
        `CHK(ramHits, 1)
        `CHK(seenA, hsif_pkg::OFF_RAM_LAST)
        `CHK(seenD, d)
        hr(7'h00, q);
        `CHK(q, 8'hA5)
        `CHK(ramReads, 1)
        results();
    end
endmodule : tb_top
